// ==== bench/mdu_chk_checker.sv ====
// Port checker for the multiply/divide unit
// Assumes binding onto mdu_unit, control word at 12'h3BC
`timescale 1ns/100ps
`default_nettype none
module mdu_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire busy
);
  // Control access and start strobe
  wire ctl = psel && penable && paddr == 12'h3BC;
  wire go = ctl && pwrite && pwdata[7];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_start; !busy && go |=> busy; endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_cause; $rose(busy) |-> $past(go); endproperty
  a_cause: assert property (p_cause) else $error("stray start");
  property p_len; $rose(busy) |-> busy[*8] ##1 busy[*8] ##1 !busy; endproperty
  a_len: assert property (p_len) else $error("bad length");
  property p_fall; $fell(busy) |-> $past(busy, 16); endproperty
  a_fall: assert property (p_fall) else $error("early end");
  property p_zero; !busy && ctl && pwrite && !pwdata[7] |=> !busy; endproperty
  a_zero: assert property (p_zero) else $error("zero started");
  property p_read; ctl && !pwrite |=> prdata[7] == $past(busy); endproperty
  a_read: assert property (p_read) else $error("bad start bit");
  property p_bound; go |-> ##[1:17] !busy; endproperty
  a_bound: assert property (p_bound) else $error("restarted");
  property p_rst; $rose(presetn) |-> !busy; endproperty
  a_rst: assert property (p_rst) else $error("busy at reset");
endmodule
bind mdu_unit mdu_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .busy(busy));
`default_nettype wire

// ==== bench/mdu_cpu.sv ====
// Processor side model: APB master for register access
// Assumes one word per register at four times its index
`timescale 1ns/100ps
`default_nettype none
module mdu_cpu (
  input wire pclk,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  int timeouts = 0;
  logic err = 1'b0;
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
  end
  // One transfer, held until pready for at most nine edges
  task xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 9);
    // Error flag taken at the completing edge; a used-up bound is counted
    err = pslverr;
    if (pready !== 1'b1) timeouts++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read; data lands one cycle after access
  task rd(input logic [7:0] i, output logic [7:0] q);
    xfer(1'b0, i, 8'h00);
    @(posedge pclk);
    q = prdata[7:0];
  endtask
endmodule
`default_nettype wire

// ==== bench/tb_mdu_unit.sv ====
// Self-checking bench for the multiply/divide unit
// Assumes mdu_cpu as bus master and the bound checker
`timescale 1ns/100ps
`default_nettype none
module tb_mdu_unit;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  wire psel, penable, pwrite, pready, pslverr, busy;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [3:0] pstrb;
  int fail_count = 0;
  int compares = 0;
  localparam logic [31:0] DA = 32'h8765_4321;
  initial forever #20 pclk = ~pclk;
  mdu_unit u_mdu_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busy(busy));
  mdu_cpu u_mdu_cpu (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb));
  task cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s exp %h got %h", s, e, g);
    end
  endtask
  task test_done;
    cmp("bus timeouts", 32'h0, u_mdu_cpu.timeouts);
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Read n bytes downward from index i+n-1 to index i
  task rd32(input logic [7:0] i, input int n, output logic [31:0] v);
    logic [7:0] b;
    v = 0;
    for (int k = n - 1; k >= 0; k--) begin
      u_mdu_cpu.rd(i + k[7:0], b);
      v = {v[23:0], b};
    end
  endtask
  // Load, start, poke while busy, poll, check both results
  task run_op(input logic [31:0] a, input logic [15:0] b, input logic [7:0] c,
    input logic [31:0] eq, input logic [15:0] eo);
    logic [31:0] v;
    for (int k = 0; k < 4; k++) u_mdu_cpu.xfer(1'b1, 8'hE9 + k[7:0], a[8*k+:8]);
    u_mdu_cpu.xfer(1'b1, 8'hED, b[7:0]);
    u_mdu_cpu.xfer(1'b1, 8'hEE, b[15:8]);
    u_mdu_cpu.xfer(1'b1, 8'hEF, c);
    u_mdu_cpu.xfer(1'b1, 8'hEF, 8'h00);
    cmp("busy", 32'h1, {31'h0, busy});
    u_mdu_cpu.xfer(1'b1, 8'hEF, 8'h80);
    v = 32'h80;
    for (int k = 0; k < 20 && v[7] !== 1'b0; k++) rd32(8'hEF, 1, v);
    cmp("start bit", 32'h0, v & 32'h80);
    cmp("busy", 32'h0, {31'h0, busy});
    if (v[7] !== 1'b0) test_done();
    rd32(8'hE9, 4, v);
    cmp("accum", eq, v);
    rd32(8'hED, 2, v);
    cmp("operand", {16'h0000, eo}, v);
  endtask
  // Select written without start while idle; unmapped access errors
  task t_ctl;
    logic [31:0] v;
    u_mdu_cpu.xfer(1'b1, 8'hEF, 8'h40);
    cmp("slave error", 32'h0, {31'h0, u_mdu_cpu.err});
    rd32(8'hEF, 1, v);
    cmp("control", 32'h40, v);
    u_mdu_cpu.xfer(1'b1, 8'hEF, 8'h00);
    rd32(8'hEF, 1, v);
    cmp("control", 32'h0, v);
    u_mdu_cpu.xfer(1'b0, 8'hF0, 8'h00);
    cmp("slave error", 32'h1, {31'h0, u_mdu_cpu.err});
  endtask
  task t_reset;
    logic [31:0] v;
    for (int k = 0; k < 7; k++) begin
      rd32(8'hE9 + k[7:0], 1, v);
      cmp("reset value", 32'h0, v);
    end
  endtask
  task t_div;
    run_op(DA, 16'h00FF, 8'hC0, DA / 32'hFF, 16'(DA % 32'hFF));
  endtask
  task t_mul;
    run_op(32'hABCD_FFFF, 16'hFFFF, 8'h80, 32'hFFFE_0001, 16'hFFFF);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ctl();
    t_div();
    t_mul();
    test_done();
  end
endmodule
`default_nettype wire

// ==== hdl/mdu_unit.v ====
// Multiply/divide unit with APB register access
// Assumes an APB master on pclk; software keeps off operands while busy
//
// What this block does
// - Unsigned 16x16 multiply to 32 bits; 32 by 16 bit divide.
// - Writing one to control bit 7 while idle launches one operation on held operands.
// - Start bit reads one while busy, zero once the result is ready.
// - Only writing one to start acts; writing zero changes nothing.
// - Bit 6 selects multiply at zero, divide at one; both reset zero.
// - Multiply: accumulator 1:0 times operand; product to accumulator 3:0.
// - Divide: accumulator by operand; quotient to accumulator, remainder operand.
// - Every operation finishes sixteen clock periods after its start.
`timescale 1ns/100ps
`default_nettype none
`include "mdu_defs.vh"

module mdu_unit (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire busy
);

  // ==================================================================
  // Address decode helper
  function [2:0] mdu_decode;
    input [11:0] addr;
    begin
      if (addr[1:0] != 2'b00) begin
        mdu_decode = 3'd7;
      end else if (addr[11:2] == {2'b00, `MDU_IDX_ACC0}) begin
        mdu_decode = 3'd0;
      end else if (addr[11:2] == {2'b00, `MDU_IDX_ACC1}) begin
        mdu_decode = 3'd1;
      end else if (addr[11:2] == {2'b00, `MDU_IDX_ACC2}) begin
        mdu_decode = 3'd2;
      end else if (addr[11:2] == {2'b00, `MDU_IDX_ACC3}) begin
        mdu_decode = 3'd3;
      end else if (addr[11:2] == {2'b00, `MDU_IDX_OPL}) begin
        mdu_decode = 3'd4;
      end else if (addr[11:2] == {2'b00, `MDU_IDX_OPH}) begin
        mdu_decode = 3'd5;
      end else if (addr[11:2] == {2'b00, `MDU_IDX_CTRL}) begin
        mdu_decode = 3'd6;
      end else begin
        mdu_decode = 3'd7;
      end
    end
  endfunction

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  reg [31:0] acc_q;
  reg [15:0] opr_q;
  reg sel_q;
  reg state_q;
  reg [4:0] cnt_q;
  reg [31:0] res_acc_q;
  reg [15:0] res_opr_q;

  wire [2:0] reg_sel;
  wire wr_en;
  wire rd_en;
  wire start_req;
  wire [31:0] div_rem;

  // Remainder fits the divisor width, so the upper half is zero for any nonzero divisor
  assign div_rem = acc_q % {16'h0000, opr_q};

  // ==================================================================
  // APB slave: zero wait states, error on unmapped address
  assign reg_sel = mdu_decode(paddr);
  assign pready = 1'b1;
  assign pslverr = psel & penable & (reg_sel == 3'd7);
  assign wr_en = psel & penable & pwrite & (reg_sel != 3'd7) & pstrb[0];
  assign rd_en = psel & penable & ~pwrite;
  assign busy = (state_q == ST_RUN);

  // Start only on a written one and only when idle
  assign start_req = wr_en & (reg_sel == 3'd6) &
    pwdata[`MDU_CTRL_START_BIT] & ~busy;

  // ==================================================================
  // Read data register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (reg_sel)
        3'd0: prdata <= {24'h00_0000, acc_q[7:0]};
        3'd1: prdata <= {24'h00_0000, acc_q[15:8]};
        3'd2: prdata <= {24'h00_0000, acc_q[23:16]};
        3'd3: prdata <= {24'h00_0000, acc_q[31:24]};
        3'd4: prdata <= {24'h00_0000, opr_q[7:0]};
        3'd5: prdata <= {24'h00_0000, opr_q[15:8]};
        3'd6: prdata <= {24'h00_0000, busy, sel_q, 6'h00};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==================================================================
  // Operation select bit, writable only while idle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= `MDU_RST_BIT;
    end else if (wr_en && reg_sel == 3'd6 && !busy) begin
      sel_q <= pwdata[`MDU_CTRL_SELECT_BIT];
    end
  end

  // ==================================================================
  // Sequencer: captures the result, then holds it sixteen cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 5'h00;
      res_acc_q <= 32'h0000_0000;
      res_opr_q <= 16'h0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_req) begin
            state_q <= ST_RUN;
            cnt_q <= 5'h01;
            if (pwdata[`MDU_CTRL_SELECT_BIT]) begin
              // Divide by zero gives an all-ones quotient and accumulator 1:0 as remainder
              if (opr_q == 16'h0000) begin
                res_acc_q <= 32'hFFFF_FFFF;
                res_opr_q <= acc_q[15:0];
              end else begin
                res_acc_q <= acc_q / {16'h0000, opr_q};
                res_opr_q <= div_rem[15:0];
              end
            end else begin
              res_acc_q <= acc_q[15:0] * opr_q;
              res_opr_q <= opr_q;
            end
          end
        end
        ST_RUN: begin
          if (cnt_q == `MDU_CNT_LAST) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
          end else begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==================================================================
  // Operand registers: software bytes, loaded with results at the end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= {4{`MDU_RST_BYTE}};
      opr_q <= {2{`MDU_RST_BYTE}};
    end else if (busy && cnt_q == `MDU_CNT_LAST) begin
      acc_q <= res_acc_q;
      opr_q <= res_opr_q;
    end else if (wr_en && !busy) begin
      case (reg_sel)
        3'd0: acc_q[7:0] <= pwdata[7:0];
        3'd1: acc_q[15:8] <= pwdata[7:0];
        3'd2: acc_q[23:16] <= pwdata[7:0];
        3'd3: acc_q[31:24] <= pwdata[7:0];
        3'd4: opr_q[7:0] <= pwdata[7:0];
        3'd5: opr_q[15:8] <= pwdata[7:0];
        default: acc_q <= acc_q;
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== pkg/mdu_defs.vh ====
// Register map, field positions and timing counts of the multiply/divide unit
// Assumes inclusion by the unit's design file, one APB word per register
`ifndef MDU_DEFS_VH
`define MDU_DEFS_VH

// ====================================================================
// Register indices; byte address is four times each index
`define MDU_IDX_ACC0 8'hE9
`define MDU_IDX_ACC1 8'hEA
`define MDU_IDX_ACC2 8'hEB
`define MDU_IDX_ACC3 8'hEC
`define MDU_IDX_OPL 8'hED
`define MDU_IDX_OPH 8'hEE
`define MDU_IDX_CTRL 8'hEF

// ====================================================================
// Control register fields
`define MDU_CTRL_START_BIT 7
`define MDU_CTRL_SELECT_BIT 6

// ====================================================================
// Reset values
`define MDU_RST_BYTE 8'h00
`define MDU_RST_BIT 1'b0

// ====================================================================
// Timing: one operation takes this many system clock periods
`define MDU_OP_PERIODS 16
`define MDU_CNT_LAST 5'h10

`endif
